// File: design/ddr_odt_defs.svh
`ifndef DDR_ODT_DEFS_SVH
`define DDR_ODT_DEFS_SVH
// **********
// Register byte offsets
// **********
`define OFF_TERM_HOLD   8'h00
`define OFF_COLMAP      8'h04
`define OFF_TERM_DELAY  8'h08
`define OFF_STATUS      8'h0C
// **********
// Field positions
// **********
`define RD_HOLD_LSB     6
`define WR_HOLD_LSB     2
`define STALL_LSB       0
`define COL_B5_LSB      12
`define COL_B6_LSB      8
`define WMERGE_DIS_BIT  5
`define ACT_FP_DIS_BIT  4
`define RD_FP_DIS_BIT   3
`define PRE_FP_DIS_BIT  2
`define COLL_AP_BIT     1
`define RD_DELAY_LSB    8
`define WR_DELAY_LSB    4
// **********
// Writable masks and reset values
// **********
`define TERM_HOLD_MASK  32'h0000_03FF
`define COLMAP_MASK     32'h0000_FF3E
`define TERM_DELAY_MASK 32'h0000_0FF0
`define TERM_HOLD_RST   32'h0000_0000
`define COLMAP_RST      32'h0000_0000
`define TERM_DELAY_RST  32'h0000_0000
// **********
// Internal bases of the column map
// **********
`define COL_B5_BASE     5'h05
`define COL_B6_BASE     5'h06
`endif

// File: design/ddr_odt_pkg.sv
package ddr_odt_pkg;
   // Bus width modes of the memory data bus
   typedef enum logic [1:0] {
      WIDTH_FULL    = 2'b00,
      WIDTH_HALF    = 2'b01,
      WIDTH_QUARTER = 2'b10
   } bus_width_t;

   // One command leaving the scheduler
   typedef struct packed {
      logic        valid;      // Command issued this cycle
      logic        isWrite;    // Write when high, read when low
      logic        highPrio;   // High-priority request
      logic        pageHit;    // Page already open
      logic        needsAct;   // Needs an activate first
      logic        needsPre;   // Needs a precharge first
      logic        termChange; // Write changes termination settings
      logic [31:0] addr;       // Host address
   } cmd_t;

   // Decisions that the block hands back
   typedef struct packed {
      logic colBit5;        // Mapped column bit five
      logic colBit6;        // Mapped column bit six
      logic writeMerge;     // Write merged into previous one
      logic collisionFlush; // Previous command flushed
      logic flushAutoPre;   // Flushed command uses auto-precharge
      logic actFastpath;    // Activate takes bypass path
      logic readFastpath;   // Read page hit takes bypass path
      logic preFastpath;    // Precharge takes bypass path
   } decision_t;
endpackage : ddr_odt_pkg

// File: design/ddr_odt_hold_and_colmap_ctrl.sv
// Summary of operation
// (RL1) Read holds termination for field plus one
// (RL2) Write holds termination for field plus one
// (RL3) Termination-changing write stalls scheduling one-three cycles
// (RL4) Column bit five source shifts with width
// (RL5) Column bit six base six, shifts width
// (RL6) Source equals base plus field plus width shift; software zero-seven
// (RL7) Merge disable stops combining same-address writes
// (RL8) Activate bypass disable forces normal path
// (RL9) Read bypass disable blocks page-hit bypass
// (RL10) Precharge bypass disable forces normal path
// (RL11) Collision page bit zero: no auto-precharge
// (RL12) Collisions: WR-RD, RD-WR, WR-WR unmerged, skip word bits
// (RL13) Termination starts after programmed delay, then hold
// (RL14) Reserved bits read zero, writes ignored
`include "ddr_odt_defs.svh"

module ddr_odt_hold_and_colmap_ctrl (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]             awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   // AXI4-Lite write response
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   // AXI4-Lite read
   input  wire logic [7:0]             araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   // Scheduler side
   input  wire ddr_odt_pkg::bus_width_t busWidth,
   input  wire ddr_odt_pkg::cmd_t       cmd,
   output ddr_odt_pkg::decision_t       decision,
   output logic                        memoryTerminationSignal,
   output logic                        schedStall
);
   // **********
   // Reset synchroniser
   // **********
   logic       rstMeta;   // First stage, read only by second
   logic       rstSyncN;  // Released reset used everywhere

   // Two flops so release never lands mid-cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end
      else
      begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   // **********
   // Functions
   // **********
   // Byte-lane merge
   function automatic logic [31:0] applyStrobe(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb,
                                               input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res & mask; // RL14
   endfunction : applyStrobe

   // Source bit: base plus field plus shift
   function automatic logic [4:0] colSource(input logic [4:0]             base,
                                            input logic [3:0]             field,
                                            input ddr_odt_pkg::bus_width_t mode);
      logic [4:0] shift;
      shift = 5'h01;
      if (mode == ddr_odt_pkg::WIDTH_HALF)
      begin
         shift = 5'h02;
      end
      else if (mode == ddr_odt_pkg::WIDTH_QUARTER)
      begin
         shift = 5'h03;
      end
      return base + {2'b00, field[2:0]} + shift; // RL6
   endfunction : colSource

   // **********
   // Configuration registers
   // **********
   logic [31:0] termHold;   // Hold counts and stall code
   logic [31:0] colMap;     // Column map and options
   logic [31:0] termDelay;  // Start delays
   logic        awTaken;    // Write address captured
   logic        wTaken;     // Write data captured
   logic [7:0]  awAddrHeld; // Captured write address
   logic [31:0] wDataHeld;  // Captured write data
   logic [3:0]  wStrbHeld;  // Captured byte enables

   // Field views
   logic [3:0] readTermHoldCycles;
   logic [3:0] writeTermHoldCycles;
   logic [1:0] termChangeSchedStall;
   logic [3:0] columnBit5SourceSel;
   logic [3:0] columnBit6SourceSel;
   logic       writeMergeDisable;
   logic       activateFastpathDisable;
   logic       readFastpathDisable;
   logic       prechargeFastpathDisable;
   logic       collisionAutoprechargeCtrl;
   logic [3:0] readTermStartDelay;
   logic [3:0] writeTermStartDelay;

   assign readTermHoldCycles         = termHold[`RD_HOLD_LSB +: 4];
   assign writeTermHoldCycles        = termHold[`WR_HOLD_LSB +: 4];
   assign termChangeSchedStall       = termHold[`STALL_LSB +: 2];
   assign columnBit5SourceSel        = colMap[`COL_B5_LSB +: 4];
   assign columnBit6SourceSel        = colMap[`COL_B6_LSB +: 4];
   assign writeMergeDisable          = colMap[`WMERGE_DIS_BIT];
   assign activateFastpathDisable    = colMap[`ACT_FP_DIS_BIT];
   assign readFastpathDisable        = colMap[`RD_FP_DIS_BIT];
   assign prechargeFastpathDisable   = colMap[`PRE_FP_DIS_BIT];
   assign collisionAutoprechargeCtrl = colMap[`COLL_AP_BIT];
   assign readTermStartDelay         = termDelay[`RD_DELAY_LSB +: 4];
   assign writeTermStartDelay        = termDelay[`WR_DELAY_LSB +: 4];

   // Write channel: address and data taken in either order
   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         awready    <= 1'b1;
         wready     <= 1'b1;
         awTaken    <= 1'b0;
         wTaken     <= 1'b0;
         awAddrHeld <= 8'h00;
         wDataHeld  <= 32'h0000_0000;
         wStrbHeld  <= 4'h0;
         bvalid     <= 1'b0;
         bresp      <= 2'b00;
      end
      else
      begin
         // Capture address
         if (awvalid && awready)
         begin
            awTaken    <= 1'b1;
            awAddrHeld <= awaddr;
            awready    <= 1'b0;
         end
         // Capture data
         if (wvalid && wready)
         begin
            wTaken    <= 1'b1;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
            wready    <= 1'b0;
         end
         // Both present: answer, unmapped gets SLVERR
         if (awTaken && wTaken && !bvalid)
         begin
            bvalid <= 1'b1;
            if (awAddrHeld == `OFF_TERM_HOLD || awAddrHeld == `OFF_COLMAP ||
                awAddrHeld == `OFF_TERM_DELAY || awAddrHeld == `OFF_STATUS)
            begin
               bresp <= 2'b00;
            end
            else
            begin
               bresp <= 2'b10;
            end
         end
         // Response taken: reopen both channels
         if (bvalid && bready)
         begin
            bvalid  <= 1'b0;
            awTaken <= 1'b0;
            wTaken  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Register update
   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         termHold  <= `TERM_HOLD_RST;
         colMap    <= `COLMAP_RST;
         termDelay <= `TERM_DELAY_RST;
      end
      else if (awTaken && wTaken && !bvalid)
      begin
         if (awAddrHeld == `OFF_TERM_HOLD)
         begin
            termHold <= applyStrobe(termHold, wDataHeld, wStrbHeld, `TERM_HOLD_MASK);
         end
         else if (awAddrHeld == `OFF_COLMAP)
         begin
            colMap <= applyStrobe(colMap, wDataHeld, wStrbHeld, `COLMAP_MASK);
         end
         else if (awAddrHeld == `OFF_TERM_DELAY)
         begin
            termDelay <= applyStrobe(termDelay, wDataHeld, wStrbHeld, `TERM_DELAY_MASK);
         end
      end
   end

   // Read channel
   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= 2'b00;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= 2'b00;
         if (araddr == `OFF_TERM_HOLD)
         begin
            rdata <= termHold;
         end
         else if (araddr == `OFF_COLMAP)
         begin
            rdata <= colMap;
         end
         else if (araddr == `OFF_TERM_DELAY)
         begin
            rdata <= termDelay;
         end
         else if (araddr == `OFF_STATUS)
         begin
            // Live view of termination and stall
            rdata <= {30'h0000_0000, schedStall, memoryTerminationSignal};
         end
         else
         begin
            rdata <= 32'h0000_0000;
            rresp <= 2'b10;
         end
      end
      else if (rvalid && rready)
      begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // **********
   // Termination timing
   // **********
   logic       startPending; // Command waiting out its delay
   logic [3:0] startCnt;     // Delay cycles left
   logic [3:0] pendHold;     // Hold value of the waiting command
   logic [3:0] holdCnt;      // Hold cycles left after this one
   logic [3:0] issueDelay;   // Delay of the issued command
   logic [3:0] issueHold;    // Hold of the issued command

   assign issueDelay = cmd.isWrite ? writeTermStartDelay : readTermStartDelay; // RL13
   assign issueHold  = cmd.isWrite ? writeTermHoldCycles : readTermHoldCycles;

   // Newest command wins; one pending slot keeps it simple
   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         startPending            <= 1'b0;
         startCnt                <= 4'h0;
         pendHold                <= 4'h0;
         holdCnt                 <= 4'h0;
         memoryTerminationSignal <= 1'b0;
      end
      else if (cmd.valid && issueDelay == 4'h0)
      begin
         // No delay: on from next cycle for hold plus one
         startPending            <= 1'b0;
         memoryTerminationSignal <= 1'b1;      // RL1 RL2
         holdCnt                 <= issueHold; // RL1 RL2
      end
      else
      begin
         if (cmd.valid)
         begin
            startPending <= 1'b1; // RL13
            startCnt     <= issueDelay;
            pendHold     <= issueHold;
         end
         else if (startPending && startCnt != 4'h1)
         begin
            startCnt <= startCnt - 4'h1;
         end
         // Delay elapsed: start the hold window
         if (!cmd.valid && startPending && startCnt == 4'h1)
         begin
            startPending            <= 1'b0;
            memoryTerminationSignal <= 1'b1; // RL13
            holdCnt                 <= pendHold;
         end
         else if (holdCnt != 4'h0)
         begin
            holdCnt <= holdCnt - 4'h1; // RL1 RL2
         end
         else
         begin
            memoryTerminationSignal <= 1'b0;
         end
      end
   end

   // **********
   // Scheduling stall on termination change
   // **********
   logic [1:0] stallCnt; // Stall cycles left after this one

   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         schedStall <= 1'b0;
         stallCnt   <= 2'b00;
      end
      else if (cmd.valid && cmd.isWrite && cmd.termChange)
      begin
         schedStall <= 1'b1;
         // Codes 10 and 11 both give three cycles
         stallCnt   <= termChangeSchedStall[1] ? 2'b10 : termChangeSchedStall; // RL3
      end
      else if (stallCnt != 2'b00)
      begin
         stallCnt <= stallCnt - 2'b01; // RL3
      end
      else
      begin
         schedStall <= 1'b0;
      end
   end

   // **********
   // Column map, collisions and bypass
   // **********
   logic        lastValid;   // A previous command exists
   logic        lastIsWrite; // Previous command was a write
   logic [29:0] lastAddr;    // Previous address without word bits
   logic        sameAddr;    // Same address as previous
   logic        collide;     // Collision with previous command
   logic        merge;       // Write merged into previous write

   // Critical-word bits [1:0] do not take part
   assign sameAddr = lastValid && (cmd.addr[31:2] == lastAddr); // RL12
   assign merge    = cmd.valid && sameAddr && lastIsWrite && cmd.isWrite
                     && !writeMergeDisable; // RL7
   assign collide  = cmd.valid && sameAddr &&
                     (lastIsWrite != cmd.isWrite ||
                      (lastIsWrite && cmd.isWrite && writeMergeDisable)); // RL12

   // History of the last issued command
   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         lastValid   <= 1'b0;
         lastIsWrite <= 1'b0;
         lastAddr    <= 30'h0000_0000;
      end
      else if (cmd.valid)
      begin
         lastValid   <= 1'b1;
         lastIsWrite <= cmd.isWrite;
         lastAddr    <= cmd.addr[31:2];
      end
   end

   // Registered decisions for the scheduler
   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         decision <= '0;
      end
      else
      begin
         // Fields over seven use low three bits
         decision.colBit5 <= cmd.addr[colSource(`COL_B5_BASE, columnBit5SourceSel,
                                                busWidth)]; // RL4
         decision.colBit6 <= cmd.addr[colSource(`COL_B6_BASE, columnBit6SourceSel,
                                                busWidth)]; // RL5
         decision.writeMerge     <= merge;                           // RL7
         decision.collisionFlush <= collide;                         // RL12
         decision.flushAutoPre   <= collide && collisionAutoprechargeCtrl; // RL11
         decision.actFastpath    <= cmd.valid && cmd.highPrio && !cmd.isWrite
                                    && cmd.needsAct && !activateFastpathDisable; // RL8
         decision.readFastpath   <= cmd.valid && cmd.highPrio && !cmd.isWrite
                                    && cmd.pageHit && !readFastpathDisable; // RL9
         decision.preFastpath    <= cmd.valid && cmd.highPrio && cmd.needsPre
                                    && !prechargeFastpathDisable; // RL10
      end
   end
endmodule : ddr_odt_hold_and_colmap_ctrl

// File: test/ddr_mem_model.sv
// **********
// Termination pin seen from the memory side
// **********
module ddr_mem_model (
   // Clock
   input  wire logic clk,
   // Termination pin from the controller
   input  wire logic memoryTerminationSignal,
   // Last pulse length
   output int        termLen
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0; // Cycles high so far

   // Measure each pulse
   always @(posedge clk)
      if (memoryTerminationSignal === 1'b1)
         cnt <= cnt + 1;
      else
      begin
         if (cnt != 0)
            termLen <= cnt;
         cnt <= 0;
      end
endmodule : ddr_mem_model

// File: test/ddr_odt_hold_and_colmap_ctrl_checker.sv
// **********
// Port checker
// **********
module ddr_odt_hold_and_colmap_ctrl_checker (
   // Clock and reset
   input logic                    clk,
   input logic                    rstn,
   // Register bus
   input logic [7:0]              awaddr,
   input logic                    awvalid,
   input logic                    awready,
   input logic [31:0]             wdata,
   input logic                    wvalid,
   input logic                    wready,
   input logic                    bvalid,
   input logic                    bready,
   // Scheduler side
   input ddr_odt_pkg::bus_width_t busWidth,
   input ddr_odt_pkg::cmd_t       cmd,
   input ddr_odt_pkg::decision_t  decision,
   input logic                    memoryTerminationSignal,
   input logic                    schedStall
);
   logic [31:0] r0, r1, r2, wD; // Shadow registers, full strobes assumed
   logic [7:0]  aA;             // Captured write address
   logic [3:0]  dly;            // Start delay left
   logic [4:0]  len;            // Hold cycles left
   logic [1:0]  stl;            // Stall cycles left
   logic        lastWr, pv, pw; // Last command kind
   logic [29:0] pa;             // Last address without word bits
   wire         expTerm = (dly == 4'h0) && (len != 5'h00);
   wire         same = cmd.valid && pv && (cmd.addr[31:2] == pa);
   wire [4:0]   src5 = 5'h06 + {2'h0, r1[14:12]} + {3'h0, busWidth};
   wire [4:0]   src6 = 5'h07 + {2'h0, r1[10:8]} + {3'h0, busWidth};

   // Shadow copy
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         {r0, r1, r2, wD, aA} <= '0;
      end
      else
      begin
         if (awvalid && awready) aA <= awaddr;
         if (wvalid && wready) wD <= wdata;
         if (bvalid && bready && aA == 8'h00) r0 <= wD;
         if (bvalid && bready && aA == 8'h04) r1 <= wD;
         if (bvalid && bready && aA == 8'h08) r2 <= wD;
      end

   // Expected window and history
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         {dly, len, stl, lastWr, pv, pw, pa} <= '0;
      end
      else
      begin
         if (cmd.valid)
         begin
            lastWr <= cmd.isWrite;
            pv     <= 1'b1;
            pw     <= cmd.isWrite;
            pa     <= cmd.addr[31:2];
            dly    <= cmd.isWrite ? r2[7:4] : r2[11:8];
            len    <= {1'b0, cmd.isWrite ? r0[5:2] : r0[9:6]} + 5'h01;
         end
         else if (dly != 4'h0) dly <= dly - 4'h1;
         else if (len != 5'h00) len <= len - 5'h01;
         if (cmd.valid && cmd.isWrite && cmd.termChange)
            stl <= r0[1] ? 2'h3 : {1'b0, r0[0]} + 2'h1;
         else if (stl != 2'h0) stl <= stl - 2'h1;
      end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rd_hold; expTerm && !lastWr |-> memoryTerminationSignal; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read hold short");
   property p_wr_hold; expTerm && lastWr |-> memoryTerminationSignal; endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write hold short");
   property p_term_off; !expTerm |-> !memoryTerminationSignal; endproperty
   a_term_off: assert property (p_term_off) else $error("term long");
   property p_stall; schedStall == (stl != 2'h0); endproperty
   a_stall: assert property (p_stall) else $error("stall length wrong");
   property p_col5; cmd.valid |=> decision.colBit5 == $past(cmd.addr[src5]); endproperty
   a_col5: assert property (p_col5) else $error("col5");
   property p_col6; cmd.valid |=> decision.colBit6 == $past(cmd.addr[src6]); endproperty
   a_col6: assert property (p_col6) else $error("col6");
   property p_merge;
      same && cmd.isWrite && pw |=> decision.writeMerge != r1[5] && decision.collisionFlush == r1[5];
   endproperty
   a_merge: assert property (p_merge) else $error("write merge wrong");
   property p_mix; same && cmd.isWrite != pw |=> decision.collisionFlush; endproperty
   a_mix: assert property (p_mix) else $error("collision missed");
   property p_apre; decision.collisionFlush |-> decision.flushAutoPre == r1[1]; endproperty
   a_apre: assert property (p_apre) else $error("auto precharge wrong");
   property p_actfp;
      cmd.valid && cmd.highPrio && !cmd.isWrite && cmd.needsAct |=> decision.actFastpath != r1[4];
   endproperty
   a_actfp: assert property (p_actfp) else $error("act bypass");
   property p_rdfp;
      cmd.valid && cmd.highPrio && !cmd.isWrite && cmd.pageHit |=> decision.readFastpath != r1[3];
   endproperty
   a_rdfp: assert property (p_rdfp) else $error("read bypass wrong");
   property p_prefp; cmd.valid && cmd.highPrio && cmd.needsPre |=> decision.preFastpath != r1[2];
   endproperty
   a_prefp: assert property (p_prefp) else $error("pre bypass");
endmodule : ddr_odt_hold_and_colmap_ctrl_checker

bind ddr_odt_hold_and_colmap_ctrl ddr_odt_hold_and_colmap_ctrl_checker i_chk (.clk, .rstn,
   .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bvalid, .bready, .busWidth, .cmd,
   .decision, .memoryTerminationSignal, .schedStall);

// File: test/ddr_odt_hold_and_colmap_ctrl_tb.sv
module ddr_odt_hold_and_colmap_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, a, r;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rs;
   logic        awready, wready, bvalid, arready, rvalid, memoryTerminationSignal, schedStall;
   ddr_odt_pkg::bus_width_t busWidth = ddr_odt_pkg::WIDTH_FULL;
   ddr_odt_pkg::cmd_t       cmd = '0;
   ddr_odt_pkg::decision_t  decision;
   int miscompares = 0, cmp_count = 0, seed = 38552, termLen, n, f5, f6, fl;

   always #5 clk = ~clk;
   ddr_odt_hold_and_colmap_ctrl i_ddr_odt_hold_and_colmap_ctrl (.clk, .rstn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .busWidth, .cmd, .decision,
      .memoryTerminationSignal, .schedStall);
   ddr_mem_model i_ddr_mem_model (.clk, .memoryTerminationSignal, .termLen);

   // **********
   // Shared tasks
   // **********
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Write: AW and W together
   task axw(input logic [7:0] ad, input logic [31:0] d);
      logic aw, w;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {ad, d, 3'b111};
      aw = 1;
      w = 1;
      while (aw || w)
      begin
         @(posedge clk);
         aw = aw && !awready;
         w = w && !wready;
         awvalid <= aw;
         wvalid <= w;
      end
      while (bvalid !== 1'b1) @(posedge clk);
      rs = bresp;
      bready <= 1'b0;
   endtask : axw

   task axr(input logic [7:0] ad);
      @(posedge clk);
      {araddr, arvalid, rready} <= {ad, 2'b11};
      do
      begin
         @(posedge clk);
         arvalid <= arvalid & ~arready;
      end while (rvalid !== 1'b1);
      {r, rs} = {rdata, rresp};
      rready <= 1'b0;
   endtask : axr

   // One command
   task iss(input logic w, hp, pg, ac, pr, tc, input logic [31:0] ad);
      cmd <= '{1'b1, w, hp, pg, ac, pr, tc, ad};
      @(posedge clk);
   endtask : iss

   // Drop valid
   task stop;
      cmd.valid <= 1'b0;
      #1;
   endtask : stop

   // **********
   // Scenarios
   // **********
   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
         axr(8'(4 * i));
         chk("reset value", 0, r);
      end
      axw(8'h00, '1);
      axr(8'h00);
      chk("hold reg", 32'h3FF, r);
      axw(8'h04, '1);
      axr(8'h04);
      chk("map reg", 32'hFF3E, r);
      axr(8'h10);
      chk("unmapped read", 2'b10, rs);
      axw(8'h10, '1);
      chk("unmapped write", 2'b10, rs);
      axw(8'h04, '0);
      // Hold lengths
      for (int h = 0; h < 16; h += 5)
      begin
         axw(8'h00, 32'((h << 6) | ((15 - h) << 2)));
         iss(0, 0, 0, 0, 0, 0, $random(seed));
         stop;
         repeat (20) @(posedge clk);
         chk("read hold", h + 1, termLen);
         iss(1, 0, 0, 0, 0, 0, $random(seed));
         stop;
         repeat (20) @(posedge clk);
         chk("write hold", 16 - h, termLen);
      end
      // Every stall code
      for (int c = 0; c < 4; c++)
      begin
         axw(8'h00, 32'(c));
         iss(1, 0, 0, 0, 0, 1, $random(seed));
         stop;
         n = 0;
         repeat (6) @(posedge clk) n += int'(schedStall === 1'b1);
         chk("stall", c > 1 ? 3 : c + 1, n);
      end
      // Start delay: read two, write three
      axw(8'h08, 32'h0000_0230);
      for (int w = 0; w < 2; w++)
      begin
         iss(w[0], 0, 0, 0, 0, 0, $random(seed));
         stop;
         n = 0;
         do @(posedge clk) n++; while (memoryTerminationSignal !== 1'b1 && n < 30);
         chk("start delay", w ? 4 : 3, n);
         repeat (10) @(posedge clk);
      end
      axw(8'h08, '0);
      // Column bits
      for (int i = 0; i < 12; i++)
      begin
         f5 = $random(seed) & 7;
         f6 = $random(seed) & 7;
         axw(8'h04, 32'((f5 << 12) | (f6 << 8)));
         busWidth <= ddr_odt_pkg::bus_width_t'(i % 3);
         a = $random(seed);
         iss(0, 0, 0, 0, 0, 0, a);
         stop;
         chk("col5", a[6 + f5 + i % 3], decision.colBit5);
         chk("col6", a[7 + f6 + i % 3], decision.colBit6);
      end
      // Collisions
      for (int m = 0; m < 4; m++)
      begin
         axw(8'h04, 32'((m[0] << 5) | (m[1] << 1)));
         for (int k = 0; k < 4; k++)
         begin
            a = $random(seed);
            @(posedge clk);
            iss(k[1], 0, 0, 0, 0, 0, a);
            iss(k[0], 0, 0, 0, 0, 0, a ^ 32'h3);
            stop;
            fl = k == 3 ? m[0] : int'(k == 1 || k == 2);
            chk("flush", fl, decision.collisionFlush);
            chk("merge", k == 3 && !m[0], decision.writeMerge);
            chk("autopre", fl & m[1], decision.flushAutoPre);
         end
      end
      // Bypass paths on and off
      for (int d = 0; d < 2; d++)
      begin
         axw(8'h04, d ? 32'h1C : 32'h0);
         iss(0, 1, 1, 1, 1, 0, $random(seed));
         stop;
         chk("act bypass", !d, decision.actFastpath);
         chk("read bypass", !d, decision.readFastpath);
         chk("pre bypass", !d, decision.preFastpath);
      end
      tally_and_finish;
   end

   // Hang guard
   initial
   begin
      repeat (30000) @(posedge clk);
      miscompares++;
      tally_and_finish;
   end
endmodule : ddr_odt_hold_and_colmap_ctrl_tb
